// ---- cfm_pkg.sv ----
package cfm_pkg;

    // register word indices; the byte address on the bus is the index times four
    localparam logic [7:0]  IDX_FLAGS_A      = 8'h26;
    localparam logic [7:0]  IDX_FLAGS_B      = 8'h27;
    localparam logic [7:0]  IDX_MASK_A       = 8'h28;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h30;
    localparam logic [7:0]  IDX_IRQ_CLEAR    = 8'h31;
    localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h32;
    localparam logic [7:0]  IDX_SOFT_RESET   = 8'h33;
    localparam int          ADDR_W           = 10;

    // flag register b field positions
    localparam int          POS_SYS_SHORT    = 7;
    localparam int          POS_SYS_OVP      = 6;
    localparam int          POS_SRC_OVP      = 5;
    localparam int          POS_SRC_UVP      = 4;
    localparam int          POS_THERM_SHUT   = 2;
    // flag register a field positions
    localparam int          POS_IN2_OVP      = 1;
    localparam int          POS_IN1_OVP      = 0;

    // mask register a: bit i gates event source i (7 current reg .. 0 bus presence)
    localparam int          NUM_EVT          = 8;

    // reset values
    localparam logic [7:0]  RST_FLAGS        = 8'h00;
    localparam logic [7:0]  RST_MASK_A       = 8'h00;
    localparam logic [7:0]  RST_IRQ_ENABLE   = 8'h00;
    localparam logic [7:0]  FLAGS_B_USED     = 8'hF4;
    localparam logic [7:0]  FLAGS_A_USED     = 8'h03;

    // interrupt pulse length
    localparam int          PULSE_NS         = 100;
    localparam int          CLK_NS           = 20;
    localparam logic [3:0]  PULSE_CYC        = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);

    // status bit positions for the sticky interrupt register
    localparam int          STS_FAULT        = 0;
    localparam int          STS_EVENT        = 1;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// ---- cfm_edge_sync.sv ----
`timescale 1ns/1ps
module cfm_edge_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] any_edge_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } cfm_sync_t;

    cfm_sync_t st_reg;
    cfm_sync_t st_next;

    // two stage synchroniser plus one delay for edges
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // edges look only at second and third stage
    assign level_out    = st_reg.s2;
    assign rise_out     = st_reg.s2 & ~st_reg.s3;
    assign any_edge_out = st_reg.s2 ^ st_reg.s3;
endmodule

// ---- cfm_pulse_gen.sv ----
`timescale 1ns/1ps
module cfm_pulse_gen
    import cfm_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic trigger,
    output logic      pulse
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       out;
    } cfm_pulse_t;

    cfm_pulse_t st_reg;
    cfm_pulse_t st_next;

    // fixed length pulse, retriggers restart the count
    always_comb begin
        st_next = st_reg;
        if (trigger) begin
            st_next.cnt = PULSE_CYC;
            st_next.out = 1'b1;
        end else if (st_reg.cnt > 4'h1) begin
            st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
            st_next.cnt = 4'h0;
            st_next.out = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pulse = st_reg.out;
endmodule

// ---- cfm_fault_mask_bank.sv ----
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - system rail short latches flag b bit 7
// RULE2 - system rail overvoltage latches flag b bit 6
// RULE3 - source mode overvoltage latches bit 5
// RULE4 - source mode undervoltage latches bit 4
// RULE5 - thermal shutdown rising edge latches bit 2
// RULE6 - mask bit 7 gates current regulation entry
// RULE7 - mask bit 6 gates voltage regulation entry
// RULE8 - mask bit 5 gates watchdog expiry pulse
// RULE9 - mask bit 4 gates weak source detection
// RULE10 - mask bit 3 gates power good toggle
// RULE11 - mask bit 2 gates second input presence
// RULE12 - mask bit 1 gates first input presence
// RULE13 - mask bit 0 gates bus presence change
// RULE14 - reserved reads zero, flag writes ignored
// RULE15 - masks clear on reset and soft reset
module cfm_fault_mask_bank
    import cfm_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // protection conditions from analog detectors (asynchronous levels)
    input  wire logic                 system_rail_short,
    input  wire logic                 system_rail_overvolt,
    input  wire logic                 source_overvolt,
    input  wire logic                 source_undervolt,
    input  wire logic                 die_thermal_shutdown,
    input  wire logic                 second_input_overvolt,
    input  wire logic                 first_input_overvolt,
    // mask-gated event conditions (asynchronous levels)
    input  wire logic                 input_current_regulation,
    input  wire logic                 source_current_regulation,
    input  wire logic                 input_voltage_regulation,
    input  wire logic                 source_voltage_regulation,
    input  wire logic                 host_watchdog_expired,
    input  wire logic                 weak_source_detected,
    input  wire logic                 power_good_status,
    input  wire logic                 second_input_present,
    input  wire logic                 first_input_present,
    input  wire logic                 input_bus_present,
    // host interrupt pulse and bus interrupt level
    output logic                      host_int_pulse,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                aw_held;
        logic                w_held;
        logic [ADDR_W-1:0]   awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [7:0]          flags_a;
        logic [7:0]          flags_b;
        logic [7:0]          mask_a;
        logic [1:0]          irq_status;
        logic [1:0]          irq_enable;
        logic                irq;
        logic                evt_trig;
    } cfm_state_t;

    cfm_state_t st_reg;
    cfm_state_t st_next;

    logic [6:0]  flt_lvl;
    logic [6:0]  flt_rise;
    logic [9:0]  evt_lvl;
    logic [9:0]  evt_rise;
    logic [9:0]  evt_edge;
    logic [7:0]  evt_src;
    logic [7:0]  evt_hit;
    logic [7:0]  flag_b_set;
    logic [7:0]  flag_a_set;
    logic        pulse_q;

    ////////////////////////////////////////////////////////////////////////////
    // synchronise fault conditions and take their rising edges
    cfm_edge_sync #(.W(7)) u_flt_sync (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .async_in     ({system_rail_short, system_rail_overvolt, source_overvolt, source_undervolt,
                        die_thermal_shutdown, second_input_overvolt, first_input_overvolt}),
        .level_out    (flt_lvl),
        .rise_out     (flt_rise),
        .any_edge_out ()
    );

    // synchronise event conditions
    cfm_edge_sync #(.W(10)) u_evt_sync (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .async_in     ({input_current_regulation, source_current_regulation,
                        input_voltage_regulation, source_voltage_regulation,
                        host_watchdog_expired, weak_source_detected, power_good_status,
                        second_input_present, first_input_present, input_bus_present}),
        .level_out    (evt_lvl),
        .rise_out     (evt_rise),
        .any_edge_out (evt_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // flag set terms, reserved positions stay zero
    always_comb begin
        flag_b_set                 = 8'h00;
        flag_b_set[POS_SYS_SHORT]  = flt_lvl[6];  // RULE1
        flag_b_set[POS_SYS_OVP]    = flt_lvl[5];  // RULE2
        flag_b_set[POS_SRC_OVP]    = flt_lvl[4];  // RULE3
        flag_b_set[POS_SRC_UVP]    = flt_lvl[3];  // RULE4
        flag_b_set[POS_THERM_SHUT] = flt_rise[2]; // RULE5
        flag_a_set                 = 8'h00;
        flag_a_set[POS_IN2_OVP]    = flt_rise[1];
        flag_a_set[POS_IN1_OVP]    = flt_rise[0];
    end

    // event sources ordered by mask bit
    always_comb begin
        evt_src[7] = evt_rise[9] | evt_rise[8]; // RULE6
        evt_src[6] = evt_rise[7] | evt_rise[6]; // RULE7
        evt_src[5] = evt_rise[5];               // RULE8
        evt_src[4] = evt_rise[4];               // RULE9
        evt_src[3] = evt_edge[3];               // RULE10
        evt_src[2] = evt_edge[2];               // RULE11
        evt_src[1] = evt_edge[1];               // RULE12
        evt_src[0] = evt_edge[0];               // RULE13
    end

    // per bit mask gating, a set mask bit suppresses its source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_gate
            assign evt_hit[gi] = evt_src[gi] & ~st_reg.mask_a[gi]; // RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12 RULE13
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register file, bus handshakes and interrupt status
    always_comb begin
        logic                do_wr;
        logic                do_rd;
        logic [7:0]          wr_idx;
        logic [7:0]          rd_idx;
        logic [7:0]          wbyte;
        logic [1:0]          sts_clr;
        logic [1:0]          sts_set;
        do_wr   = 1'b0;
        do_rd   = 1'b0;
        wr_idx  = 8'h00;
        rd_idx  = 8'h00;
        wbyte   = 8'h00;
        sts_clr = 2'b00;
        sts_set = 2'b00;
        st_next = st_reg;

        // flags clear once read; hardware set wins over that clear
        st_next.evt_trig = |evt_hit;

        // write address and data captured independently
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr  = s_axi_awaddr;
            st_next.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_held = 1'b1;
            st_next.wdata  = s_axi_wdata;
            st_next.wstrb  = s_axi_wstrb;
            st_next.wready = 1'b0;
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            do_wr           = 1'b1;
            wr_idx          = st_reg.awaddr[ADDR_W-1:2];
            wbyte           = st_reg.wdata[7:0];
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid  = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
        end

        // write decode; flag registers ignore writes
        if (do_wr) begin
            case (wr_idx)
                IDX_FLAGS_A, IDX_FLAGS_B: begin
                    st_next.bresp = RESP_OKAY; // RULE14
                end
                IDX_MASK_A: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.mask_a = wbyte;
                    end
                end
                IDX_IRQ_CLEAR: begin
                    if (st_reg.wstrb[0]) begin
                        sts_clr = wbyte[1:0];
                    end
                end
                IDX_IRQ_ENABLE: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.irq_enable = wbyte[1:0];
                    end
                end
                IDX_SOFT_RESET: begin
                    if (st_reg.wstrb[0] && wbyte[0]) begin
                        st_next.mask_a = RST_MASK_A; // RULE15
                    end
                end
                default: begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (s_axi_arvalid && st_reg.arready) begin
            do_rd           = 1'b1;
            rd_idx          = s_axi_araddr[ADDR_W-1:2];
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rresp   = RESP_OKAY;
            st_next.rdata   = 32'h0000_0000;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end
        if (do_rd) begin
            case (rd_idx)
                IDX_FLAGS_A: begin
                    st_next.rdata[7:0] = st_reg.flags_a & FLAGS_A_USED; // RULE14
                    st_next.flags_a    = RST_FLAGS;
                end
                IDX_FLAGS_B: begin
                    st_next.rdata[7:0] = st_reg.flags_b & FLAGS_B_USED; // RULE14
                    st_next.flags_b    = RST_FLAGS;
                end
                IDX_MASK_A: begin
                    st_next.rdata[7:0] = st_reg.mask_a;
                end
                IDX_IRQ_STATUS: begin
                    st_next.rdata[1:0] = st_reg.irq_status;
                end
                IDX_IRQ_ENABLE: begin
                    st_next.rdata[1:0] = st_reg.irq_enable;
                end
                IDX_IRQ_CLEAR, IDX_SOFT_RESET: begin
                    st_next.rdata = 32'h0000_0000;
                end
                default: begin
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end

        // latch new fault flags after any read clear
        st_next.flags_b = st_next.flags_b | (flag_b_set & FLAGS_B_USED); // RULE1 RULE2 RULE3 RULE4 RULE5
        st_next.flags_a = st_next.flags_a | (flag_a_set & FLAGS_A_USED);

        // sticky interrupt status, set beats clear
        sts_set[STS_FAULT] = |flag_b_set | |flag_a_set;
        sts_set[STS_EVENT] = |evt_hit;
        st_next.irq_status = (st_reg.irq_status & ~sts_clr) | sts_set;
        st_next.irq        = |(st_next.irq_status & st_next.irq_enable);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg         <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.mask_a  <= RST_MASK_A; // RULE15
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host interrupt pulse on any unmasked event
    cfm_pulse_gen u_pulse (
        .clk     (clk),
        .sys_rst (sys_rst),
        .trigger (st_reg.evt_trig),
        .pulse   (pulse_q)
    );

    // outputs straight from flip-flops
    assign s_axi_awready  = st_reg.awready;
    assign s_axi_wready   = st_reg.wready;
    assign s_axi_bvalid   = st_reg.bvalid;
    assign s_axi_bresp    = st_reg.bresp;
    assign s_axi_arready  = st_reg.arready;
    assign s_axi_rvalid   = st_reg.rvalid;
    assign s_axi_rdata    = st_reg.rdata;
    assign s_axi_rresp    = st_reg.rresp;
    assign irq            = st_reg.irq;
    assign host_int_pulse = pulse_q;

endmodule

// ---- cfm_host_model.sv ----
`timescale 1ns/1ps
module cfm_host_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic host_int_pulse,
    output int        pulse_cnt
);
    logic last_q;
    // host side: counts each interrupt pulse it sees
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_q    <= 1'b0;
            pulse_cnt <= 0;
        end else begin
            last_q <= host_int_pulse;
            if (host_int_pulse && !last_q) begin
                pulse_cnt <= pulse_cnt + 1;
            end
        end
    end
endmodule

// ---- cfm_fault_mask_bank_checker.sv ----
`timescale 1ns/1ps
module cfm_fault_mask_bank_checker
    import cfm_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              host_int_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // bus steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write answer missing");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("busy write taken");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write not released");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read not released");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper data set");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h3FC
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    pulse_len_a: assert property ($rose(host_int_pulse) |-> host_int_pulse[*5]) else $error("pulse too short");
endmodule
bind cfm_fault_mask_bank cfm_fault_mask_bank_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .host_int_pulse(host_int_pulse));

// ---- charger_fault_flag_and_mask_bank_tb.sv ----
`timescale 1ns/1ps
module charger_fault_flag_and_mask_bank_tb;
    import cfm_pkg::*;
    logic              clk, sys_rst;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, pulse, irq;
    logic [6:0]        flt;
    logic [9:0]        ev;
    int                pulse_cnt, error_cnt, cmp_count;
    int                fpos[7] = '{7, 6, 5, 4, 2, 1, 0};
    int                epos[10] = '{7, 7, 6, 6, 5, 4, 3, 2, 1, 0};
    ////////////////////////////////////////////////////////////////////////////////
    cfm_fault_mask_bank dut (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .system_rail_short(flt[0]), .system_rail_overvolt(flt[1]),
        .source_overvolt(flt[2]), .source_undervolt(flt[3]), .die_thermal_shutdown(flt[4]),
        .second_input_overvolt(flt[5]), .first_input_overvolt(flt[6]),
        .input_current_regulation(ev[0]), .source_current_regulation(ev[1]),
        .input_voltage_regulation(ev[2]), .source_voltage_regulation(ev[3]),
        .host_watchdog_expired(ev[4]), .weak_source_detected(ev[5]), .power_good_status(ev[6]),
        .second_input_present(ev[7]), .first_input_present(ev[8]), .input_bus_present(ev[9]),
        .host_int_pulse(pulse), .irq(irq));
    cfm_host_model u_host (.clk(clk), .sys_rst(sys_rst), .host_int_pulse(pulse), .pulse_cnt(pulse_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [9:0] ad(logic [7:0] i);
        return {i, 2'b00};
    endfunction
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 50) begin
            error_cnt++;
            $display("unexpected at %0t: bus hang", $time);
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // bus master tasks
    task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit aw, w;
        n = 0;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            tick(n);
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do tick(n); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do tick(n); while (!arready);
        arvalid <= 1'b0;
        do tick(n); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd(ad(IDX_MASK_A), d, r);
        chk(d, 32'h0);
        rd(ad(IDX_FLAGS_B), d, r);
        chk(d, 32'h0);
        rd(ad(IDX_IRQ_ENABLE), d, r);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_faults();
        logic [31:0] d;
        logic [1:0]  r;
        logic [9:0]  a;
        for (int i = 0; i < 7; i++) begin
            a = (i < 5) ? ad(IDX_FLAGS_B) : ad(IDX_FLAGS_A);
            flt[i] <= 1'b1;
            cyc(6);
            flt[i] <= 1'b0;
            cyc(6);
            rd(a, d, r);
            chk(d, 32'h1 << fpos[i]);
            rd(a, d, r);
            chk(d, 32'h0);
        end
        wr(ad(IDX_FLAGS_B), 32'hFF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rd(ad(IDX_FLAGS_B), d, r);
        chk(d, 32'h0);
    endtask
    task automatic t_masks();
        logic [31:0] d, k;
        logic [1:0]  r;
        int          c;
        for (int i = 0; i < 10; i++) begin
            for (int m = 0; m < 2; m++) begin
                k = (m == 1) ? 32'h1 << epos[i] : 32'h0;
                wr(ad(IDX_MASK_A), k, r);
                rd(ad(IDX_MASK_A), d, r);
                chk(d, k);
                c = pulse_cnt;
                ev[i] <= 1'b1;
                cyc(12);
                chk(32'(pulse_cnt - c), (m == 1) ? 32'h0 : 32'h1);
                ev[i] <= 1'b0;
                cyc(12);
                chk(32'(pulse_cnt - c), (m == 1) ? 32'h0 : ((i > 5) ? 32'h2 : 32'h1));
            end
        end
    endtask
    task automatic t_irq();
        logic [31:0] d;
        logic [1:0]  r;
        // unmask all and drop sticky status left by earlier scenarios
        wr(ad(IDX_MASK_A), 32'h0, r);
        wr(ad(IDX_IRQ_CLEAR), 32'h3, r);
        wr(ad(IDX_IRQ_ENABLE), 32'h2, r);
        chk({31'h0, irq}, 32'h0);
        ev[9] <= 1'b1;
        cyc(8);
        chk({31'h0, irq}, 32'h1);
        rd(ad(IDX_IRQ_STATUS), d, r);
        chk({31'h0, d[STS_EVENT]}, 32'h1);
        wr(ad(IDX_IRQ_CLEAR), 32'h2, r);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        // disabled source stays quiet, then shows once enabled
        wr(ad(IDX_IRQ_ENABLE), 32'h0, r);
        ev[9] <= 1'b0;
        cyc(8);
        chk({31'h0, irq}, 32'h0);
        wr(ad(IDX_IRQ_ENABLE), 32'h2, r);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(ad(IDX_IRQ_CLEAR), 32'h3, r);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_soft();
        logic [31:0] d;
        logic [1:0]  r;
        wr(ad(IDX_MASK_A), 32'hFF, r);
        rd(ad(IDX_MASK_A), d, r);
        chk(d, 32'hFF);
        wr(ad(IDX_SOFT_RESET), 32'h1, r);
        rd(ad(IDX_MASK_A), d, r);
        chk(d, 32'h0);
        rd(10'h3FC, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        wr(10'h3FC, 32'h5A, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready, flt, ev} = '0;
        sys_rst = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_faults();
        t_masks();
        t_irq();
        t_soft();
        stop_test();
    end
endmodule
